/* File: edh_dma_handshake.sv */
// What this block does
// - every transfer starts from a falling request line and the block then runs the access.
// - in handshake mode only the grant strobe marks when outside logic latches or drives data.
// - in external handshake mode address, strobes, page, selects, ack and grant all take part.
// - in paced master mode address, strobes, selects and ack run the access and grant stays high.
// - in paced master mode the pins move as in an ordinary bus-master read or write cycle.
// - the request is sampled on the clock edge, late requests are seen one cycle later.
// - the grant and strobe low phase is stretched by the programmed wait count in clock cycles.
// - with the idle cycle set, grant high time and the gap before the next strobe grow by one cycle.
// - a request still low at the end of an outbound access holds it off until released.
// - a request still low at the end of an inbound access prolongs it one cycle per cycle low.
// - in synchronous mode the strobe rises on the same edge as the grant.
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "edh_cfg.svh"

module edh_dma_handshake #(
	parameter int NCH = 2,
	parameter int WS_W = 5,
	parameter int DATA_W = 64
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [NCH-1:0] ext_dma_request_n,
	output logic [NCH-1:0] ext_dma_grant_n,
	input wire logic ack,
	output logic [31:0] addr,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic [3:0] memory_select_n,
	output logic page,
	input wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0] data_out,
	output logic data_oe
);

	localparam int CH_W = (NCH > 1) ? $clog2(NCH) : 1;

	// ==========================================================
	// state
	typedef struct packed {
		logic en;
		logic [1:0] mode;
		logic dir;
		logic sync_mode;
		logic [NCH-1:0] chan_en;
		logic [WS_W-1:0] wait_cnt;
		logic idle_cycle_extension;
		logic [31:0] cur_addr;
		logic [15:0] count;
		logic [DATA_W-1:0] tx;
		logic [DATA_W-1:0] rx;
		logic tx_empty;
		logic rx_valid;
		logic done;
		logic [NCH-1:0] req_prev;
		logic [NCH-1:0] pending;
		edh_pkg::edh_fsm_t fsm;
		logic [CH_W-1:0] chan;
		logic [WS_W-1:0] tmr;
		logic [31:0] last_page;
		logic page_valid;
		logic [31:0] rdata;
		logic [NCH-1:0] grant_n;
		logic [31:0] addr_q;
		logic rd_n;
		logic wr_n;
		logic [3:0] ms_n;
		logic page;
		logic [DATA_W-1:0] dout;
		logic doe;
	} edh_state_t;

	edh_state_t st;
	edh_state_t next_st;

	logic [NCH:0] pin_level;
	logic [NCH-1:0] req_low;
	logic ack_ok;

	// ==========================================================
	// pin synchronisers for request lines and ack
	edh_pin_sync #(
		.W(NCH + 1),
		.INIT({(NCH + 1){1'b1}})
	) u_sync (
		.core_clk(core_clk),
		.resetn(resetn),
		.pin_in({ack, ext_dma_request_n}),
		.level(pin_level)
	);

	assign req_low = ~pin_level[NCH-1:0];
	assign ack_ok = pin_level[NCH];

	// ==========================================================
	// helpers
	function automatic logic [3:0] ms_decode(input logic [31:0] a);
		logic [1:0] bank;
		bank = a[`EDH_MS_SHIFT+1:`EDH_MS_SHIFT];
		if (a[31:`EDH_MS_SHIFT+2] != '0) begin
			ms_decode = 4'hF;
		end else begin
			ms_decode = ~(4'h1 << bank);
		end
	endfunction

	function automatic logic [31:0] page_of(input logic [31:0] a);
		page_of = a >> `EDH_PAGE_SHIFT;
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		logic found;
		logic held;
		logic ready;
		logic [DATA_W-1:0] wide;
		found = 1'b0;
		held = 1'b0;
		ready = 1'b0;
		wide = '0;
		next_st = st;

		// falling edges queue a request per channel
		next_st.req_prev = req_low;
		for (int i = 0; i < NCH; i++) begin
			if (req_low[i] && !st.req_prev[i]) begin
				next_st.pending[i] = 1'b1;
			end
		end

		// register writes
		if (reg_wr) begin
			case (reg_addr)
				`EDH_OFS_CTRL: begin
					next_st.en = reg_wdata[`EDH_CTRL_EN];
					next_st.mode = reg_wdata[`EDH_CTRL_MODE_HI:`EDH_CTRL_MODE_LO];
					next_st.dir = reg_wdata[`EDH_CTRL_DIR];
					next_st.sync_mode = reg_wdata[`EDH_CTRL_SYNC];
					next_st.chan_en = reg_wdata[`EDH_CTRL_CHEN_LO +: NCH];
				end
				`EDH_OFS_WAIT: begin
					next_st.wait_cnt = reg_wdata[`EDH_WAIT_CNT_LO +: WS_W];
					next_st.idle_cycle_extension = reg_wdata[`EDH_WAIT_IDLE];
				end
				`EDH_OFS_ADDR: begin
					next_st.cur_addr = reg_wdata;
				end
				`EDH_OFS_COUNT: begin
					next_st.count = reg_wdata[15:0];
					next_st.done = 1'b0;
				end
				`EDH_OFS_TXLO: begin
					next_st.tx[31:0] = reg_wdata;
				end
				`EDH_OFS_TXHI: begin
					wide = st.tx;
					wide[DATA_W-1:32] = reg_wdata[DATA_W-33:0];
					next_st.tx = wide;
					next_st.tx_empty = 1'b0;
				end
				default: begin
				end
			endcase
		end

		// register reads, data one cycle later
		next_st.rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				`EDH_OFS_CTRL: begin
					next_st.rdata[`EDH_CTRL_EN] = st.en;
					next_st.rdata[`EDH_CTRL_MODE_HI:`EDH_CTRL_MODE_LO] = st.mode;
					next_st.rdata[`EDH_CTRL_DIR] = st.dir;
					next_st.rdata[`EDH_CTRL_SYNC] = st.sync_mode;
					next_st.rdata[`EDH_CTRL_CHEN_LO +: NCH] = st.chan_en;
				end
				`EDH_OFS_WAIT: begin
					next_st.rdata[`EDH_WAIT_CNT_LO +: WS_W] = st.wait_cnt;
					next_st.rdata[`EDH_WAIT_IDLE] = st.idle_cycle_extension;
				end
				`EDH_OFS_ADDR: begin
					next_st.rdata = st.cur_addr;
				end
				`EDH_OFS_COUNT: begin
					next_st.rdata[15:0] = st.count;
				end
				`EDH_OFS_TXLO: begin
					next_st.rdata = st.tx[31:0];
				end
				`EDH_OFS_TXHI: begin
					next_st.rdata = st.tx[63:32];
				end
				`EDH_OFS_RXLO: begin
					next_st.rdata = st.rx[31:0];
				end
				`EDH_OFS_RXHI: begin
					next_st.rdata = st.rx[63:32];
					next_st.rx_valid = 1'b0;
				end
				`EDH_OFS_STATUS: begin
					next_st.rdata[`EDH_ST_BUSY] = (st.fsm != edh_pkg::EDH_ST_IDLE);
					next_st.rdata[`EDH_ST_RXV] = st.rx_valid;
					next_st.rdata[`EDH_ST_TXE] = st.tx_empty;
					next_st.rdata[`EDH_ST_DONE] = st.done;
					next_st.rdata[`EDH_ST_CHAN_LO +: CH_W] = st.chan;
					next_st.done = 1'b0;
				end
				default: begin
				end
			endcase
		end

		// access is held off by the requester or by the memory
		held = req_low[st.chan];
		if (st.mode != edh_pkg::EDH_MODE_HANDSHAKE && !ack_ok) begin
			held = 1'b1;
		end
		ready = st.dir ? !st.tx_empty : !st.rx_valid;

		// ==========================================================
		// access sequencer
		case (st.fsm)
			edh_pkg::EDH_ST_IDLE: begin
				if (st.en && st.count != 16'h0000 && ready) begin
					for (int i = 0; i < NCH; i++) begin
						if (!found && st.pending[i] && st.chan_en[i]) begin
							found = 1'b1;
							next_st.chan = CH_W'(i);
							next_st.pending[i] = req_low[i] && !st.req_prev[i];
							if (st.mode != edh_pkg::EDH_MODE_PACED) begin
								next_st.grant_n[i] = 1'b0;
							end
						end
					end
					if (found) begin
						next_st.fsm = edh_pkg::EDH_ST_STROBE;
						next_st.tmr = st.wait_cnt;
						next_st.doe = st.dir;
						next_st.dout = st.tx;
						if (st.mode != edh_pkg::EDH_MODE_HANDSHAKE) begin
							// address, selects, page and strobes
							next_st.addr_q = st.cur_addr;
							next_st.ms_n = ms_decode(st.cur_addr);
							next_st.page = !st.page_valid ||
								page_of(st.cur_addr) != st.last_page;
							next_st.last_page = page_of(st.cur_addr);
							next_st.page_valid = 1'b1;
							next_st.wr_n = !st.dir;
							next_st.rd_n = st.dir;
						end
					end
				end
			end
			edh_pkg::EDH_ST_STROBE: begin
				if (st.tmr != '0) begin
					next_st.tmr = st.tmr - 1'b1;
				end else begin
					next_st.fsm = edh_pkg::EDH_ST_HOLD;
				end
			end
			edh_pkg::EDH_ST_HOLD: begin
				if (!held) begin
					if (!st.dir) begin
						next_st.rx = data_in;
						next_st.rx_valid = 1'b1;
					end else begin
						next_st.tx_empty = 1'b1;
					end
					next_st.count = st.count - 16'h0001;
					if (st.count == 16'h0001) begin
						next_st.done = 1'b1;
					end
					next_st.cur_addr = st.cur_addr + `EDH_ADDR_STEP;
					next_st.rd_n = 1'b1;
					next_st.wr_n = 1'b1;
					next_st.page = 1'b0;
					if (st.sync_mode) begin
						next_st.grant_n = '1;
						next_st.doe = 1'b0;
						next_st.ms_n = 4'hF;
						next_st.fsm = edh_pkg::EDH_ST_GAP;
						next_st.tmr = WS_W'(st.idle_cycle_extension);
					end else begin
						next_st.fsm = edh_pkg::EDH_ST_RELEASE;
					end
				end
			end
			edh_pkg::EDH_ST_RELEASE: begin
				next_st.grant_n = '1;
				next_st.doe = 1'b0;
				next_st.ms_n = 4'hF;
				next_st.fsm = edh_pkg::EDH_ST_GAP;
				next_st.tmr = WS_W'(st.idle_cycle_extension);
			end
			edh_pkg::EDH_ST_GAP: begin
				if (st.tmr != '0) begin
					next_st.tmr = st.tmr - 1'b1;
				end else begin
					next_st.fsm = edh_pkg::EDH_ST_IDLE;
				end
			end
			default: begin
				next_st.fsm = edh_pkg::EDH_ST_IDLE;
				next_st.grant_n = '1;
				next_st.rd_n = 1'b1;
				next_st.wr_n = 1'b1;
				next_st.doe = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			st <= '0;
			st.wait_cnt <= `EDH_RST_WAIT;
			st.cur_addr <= `EDH_RST_ADDR;
			st.count <= `EDH_RST_COUNT;
			st.tx_empty <= 1'b1;
			st.fsm <= edh_pkg::EDH_ST_IDLE;
			st.grant_n <= '1;
			st.rd_n <= 1'b1;
			st.wr_n <= 1'b1;
			st.ms_n <= 4'hF;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// outputs
	assign reg_rdata = st.rdata;
	assign ext_dma_grant_n = st.grant_n;
	assign addr = st.addr_q;
	assign read_strobe_n = st.rd_n;
	assign write_strobe_n = st.wr_n;
	assign memory_select_n = st.ms_n;
	assign page = st.page;
	assign data_out = st.dout;
	assign data_oe = st.doe;

endmodule

`default_nettype wire

/* File: edh_cfg.svh */
`ifndef EDH_CFG_SVH
`define EDH_CFG_SVH

// ==========================================================
// register offsets (byte addresses)
`define EDH_OFS_CTRL 8'h00
`define EDH_OFS_WAIT 8'h04
`define EDH_OFS_ADDR 8'h08
`define EDH_OFS_COUNT 8'h0C
`define EDH_OFS_TXLO 8'h10
`define EDH_OFS_TXHI 8'h14
`define EDH_OFS_RXLO 8'h18
`define EDH_OFS_RXHI 8'h1C
`define EDH_OFS_STATUS 8'h20

// ==========================================================
// control register fields
`define EDH_CTRL_EN 0
`define EDH_CTRL_MODE_LO 1
`define EDH_CTRL_MODE_HI 2
`define EDH_CTRL_DIR 3
`define EDH_CTRL_SYNC 4
`define EDH_CTRL_CHEN_LO 8

// ==========================================================
// wait register fields
`define EDH_WAIT_CNT_LO 0
`define EDH_WAIT_IDLE 8

// ==========================================================
// status register fields
`define EDH_ST_BUSY 0
`define EDH_ST_RXV 1
`define EDH_ST_TXE 2
`define EDH_ST_DONE 3
`define EDH_ST_CHAN_LO 8

// ==========================================================
// reset values
`define EDH_RST_ADDR 32'h0000_0000
`define EDH_RST_COUNT 16'h0000
`define EDH_RST_WAIT 5'h00

// ==========================================================
// address map of the external bus
`define EDH_MS_SHIFT 24
`define EDH_PAGE_SHIFT 10
`define EDH_ADDR_STEP 32'h0000_0001

`endif

/* File: edh_pkg.sv */
package edh_pkg;

	// ==========================================================
	// transfer modes
	typedef enum logic [1:0] {
		EDH_MODE_HANDSHAKE = 2'h0,
		EDH_MODE_EXT_HANDSHAKE = 2'h1,
		EDH_MODE_PACED = 2'h2
	} edh_mode_t;

	// ==========================================================
	// access sequencer states
	typedef enum logic [4:0] {
		EDH_ST_IDLE = 5'b00001,
		EDH_ST_STROBE = 5'b00010,
		EDH_ST_HOLD = 5'b00100,
		EDH_ST_RELEASE = 5'b01000,
		EDH_ST_GAP = 5'b10000
	} edh_fsm_t;

endpackage

/* File: edh_pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module edh_pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '1
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} edh_sync_t;

	edh_sync_t st;
	edh_sync_t next_st;

	// a bit changes only once stages two and three agree
	always_comb begin
		next_st = st;
		next_st.s1 = pin_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < W; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.q[i] = st.s3[i];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			st <= {INIT, INIT, INIT, INIT};
		end else begin
			st <= next_st;
		end
	end

	assign level = st.q;

endmodule

`default_nettype wire

/* File: edh_dma_handshake_properties.sv */
`timescale 1ns/10ps
`default_nettype none
`include "edh_cfg.svh"

module edh_dma_handshake_properties #(
	parameter int NCH = 2
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [NCH-1:0] ext_dma_grant_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n
);
	// ==========================================================
	// shadow of mode, sync and wait settings
	logic [1:0] mode;
	logic sync;
	logic idle;
	logic [4:0] ws;
	logic [7:0] low_cnt;
	logic gnt_hi;
	logic str_hi;
	assign gnt_hi = &ext_dma_grant_n;
	assign str_hi = read_strobe_n & write_strobe_n;
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			mode <= 2'h0;
			sync <= 1'b0;
			idle <= 1'b0;
			ws <= 5'h00;
			low_cnt <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == `EDH_OFS_CTRL) begin
				mode <= reg_wdata[`EDH_CTRL_MODE_HI:`EDH_CTRL_MODE_LO];
				sync <= reg_wdata[`EDH_CTRL_SYNC];
			end
			if (reg_wr && reg_addr == `EDH_OFS_WAIT) begin
				ws <= reg_wdata[`EDH_WAIT_CNT_LO +: 5];
				idle <= reg_wdata[`EDH_WAIT_IDLE];
			end
			low_cnt <= gnt_hi ? 8'h00 : low_cnt + 8'h01;
		end
	end

	// ==========================================================
	// properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// grant stays high two cycles, three with the idle cycle
	sequence gap_base_s;
		gnt_hi[*2];
	endsequence
	sequence gap_idle_s;
		gnt_hi[*3];
	endsequence
	paced_grant_off_a: assert property (
		mode == edh_pkg::EDH_MODE_PACED |-> gnt_hi)
		else $error("grant low in paced mode");
	hs_strobes_idle_a: assert property (
		mode == edh_pkg::EDH_MODE_HANDSHAKE |-> str_hi)
		else $error("strobe low in handshake mode");
	one_grant_a: assert property ($onehot0(~ext_dma_grant_n))
		else $error("two grants low");
	no_both_strobes_a: assert property (!(!read_strobe_n && !write_strobe_n))
		else $error("both strobes low");
	ext_strobe_with_a: assert property (
		mode == edh_pkg::EDH_MODE_EXT_HANDSHAKE && $fell(gnt_hi) |-> !str_hi)
		else $error("grant fell without strobe");
	sync_rise_a: assert property (
		sync && mode == edh_pkg::EDH_MODE_EXT_HANDSHAKE && $rose(str_hi)
		|-> $rose(gnt_hi))
		else $error("sync strobe and grant rise apart");
	nonsync_rise_a: assert property (
		!sync && mode == edh_pkg::EDH_MODE_EXT_HANDSHAKE && $rose(str_hi)
		|=> $rose(gnt_hi))
		else $error("grant not one cycle after strobe");
	wait_stretch_a: assert property (
		$rose(gnt_hi) |-> low_cnt >= 8'h02 + {3'h0, ws})
		else $error("grant low phase too short");
	gap_base_a: assert property ($rose(gnt_hi) |-> gap_base_s)
		else $error("grant high gap too short");
	gap_idle_a: assert property (idle && $rose(gnt_hi) |-> gap_idle_s)
		else $error("idle cycle missing from gap");
endmodule

`default_nettype wire

/* File: edh_ext_dev.sv */
`timescale 1ns/10ps
`default_nettype none

module edh_ext_dev #(
	parameter int NCH = 2
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [NCH-1:0] go,
	input wire logic [3:0] hold,
	input wire logic [63:0] word,
	input wire logic [NCH-1:0] ext_dma_grant_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic data_oe,
	input wire logic [63:0] data_out,
	output logic [NCH-1:0] ext_dma_request_n,
	output logic ack,
	output logic [63:0] data_in,
	output logic [63:0] got
);
	int left [NCH];
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < NCH; i++) begin
			if (!resetn)
				left[i] <= 0;
			else if (go[i])
				left[i] <= 1 + hold;
			else if (left[i] > 0)
				left[i] <= left[i] - 1;
		end
		// ready one cycle late, so every strobed access sees a slow answer
		ack <= !(read_strobe_n && write_strobe_n);
		if (data_oe)
			got <= data_out;
	end
	always_comb begin
		for (int i = 0; i < NCH; i++)
			ext_dma_request_n[i] = (left[i] == 0);
	end
	// data only after the request is released, scrambled otherwise
	assign data_in = ((!read_strobe_n || !(&ext_dma_grant_n))
		&& (&ext_dma_request_n)) ? word : ~word;
endmodule

`default_nettype wire

/* File: edh_dma_handshake_bench.sv */
`timescale 1ns/10ps
`default_nettype none

module edh_dma_handshake_bench;
	localparam logic [63:0] WORD = 64'hA5C3_0F1E_9B7D_2468;
	logic core_clk, resetn, reg_wr, reg_rd, ack, data_oe;
	logic read_strobe_n, write_strobe_n;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [1:0] req_n, gnt_n, go;
	logic [3:0] hold;
	logic [63:0] data_in, data_out, got;
	logic [31:0] bus_addr, seen_addr;
	logic [3:0] bus_ms_n, seen_ms_n;
	logic bus_page, seen_page;
	logic [1:0] seen_gnt_n;
	int n_errors = 0;
	int n_tests = 0;
	int cyc = 0;

	edh_dma_handshake edh_dma_handshake_i (.core_clk(core_clk),
		.resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ext_dma_request_n(req_n), .ext_dma_grant_n(gnt_n), .ack(ack),
		.addr(bus_addr), .read_strobe_n(read_strobe_n),
		.write_strobe_n(write_strobe_n), .memory_select_n(bus_ms_n),
		.page(bus_page),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe));
	edh_ext_dev edh_ext_dev_i (.core_clk(core_clk), .resetn(resetn),
		.go(go), .hold(hold), .word(WORD), .ext_dma_grant_n(gnt_n),
		.read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
		.data_oe(data_oe), .data_out(data_out), .ext_dma_request_n(req_n),
		.ack(ack), .data_in(data_in), .got(got));

	always #25 core_clk = ~core_clk;

	// ==========================================================
	// what the block showed on the far-side bus in the last access
	always @(posedge core_clk) begin
		if (go != 2'h0) begin
			seen_addr <= 32'h0000_0000;
			seen_ms_n <= 4'hF;
			seen_page <= 1'b0;
			seen_gnt_n <= 2'h3;
		end else begin
			if (!read_strobe_n || !write_strobe_n) begin
				seen_addr <= bus_addr;
				seen_ms_n <= bus_ms_n;
				seen_page <= bus_page;
			end
			if (gnt_n != 2'h3)
				seen_gnt_n <= gnt_n;
		end
	end

	// ==========================================================
	// register access and checking
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
		@(posedge core_clk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		chk({32'h0, d}, {32'h0, e});
	endtask
	task automatic final_report();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ==========================================================
	// one transfer: mode m, direction and sync d, wait 2m, idle d
	task automatic xfer(input logic [1:0] m, input logic d);
		logic [31:0] s;
		logic [31:0] a0;
		logic ch;
		ch = m[0] ^ d;
		a0 = 32'h0000_0100 * (m + 1);
		wr(8'h04, {23'h0, d, 3'h0, 2'h0, m, 1'b0});
		wr(8'h08, a0);
		wr(8'h0C, 32'h0000_0001);
		if (d) begin
			wr(8'h10, WORD[31:0]);
			wr(8'h14, WORD[63:32]);
		end
		wr(8'h00, {22'h0, 2'h3, 3'h0, d, d, m, 1'b1});
		go <= ch ? 2'h2 : 2'h1;
		hold <= 4'h5 + {1'b0, m, 1'b0};
		@(posedge core_clk);
		go <= 2'h0;
		s = 32'h0;
		for (int k = 0; k < 100 && !s[3]; k++)
			rd(8'h20, s);
		chk(s[3], 1'b1);
		chk(s[8], ch);
		if (d)
			chk(got, WORD);
		else begin
			rc(8'h18, WORD[31:0]);
			rc(8'h1C, WORD[63:32]);
		end
		rc(8'h08, a0 + 32'h0000_0001);
		if (m != 2'h0) begin
			chk(seen_addr, a0);
			chk(seen_ms_n, 4'hE);
			chk(seen_page, m == 2'h1 && !d);
		end
		chk(seen_gnt_n, (m == 2'h2) ? 2'h3 : {!ch, ch});
		wr(8'h00, 32'h0000_0000);
	endtask

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			final_report();
		end
	end

	initial begin
		core_clk = 1'b0;
		resetn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		go = 2'h0;
		hold = 4'h0;
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		rc(8'h20, 32'h0000_0004);
		rc(8'h40, 32'h0000_0000);
		for (int m = 0; m < 3; m++)
			for (int d = 0; d < 2; d++)
				xfer(m[1:0], d[0]);
		final_report();
	end
endmodule

bind edh_dma_handshake edh_dma_handshake_properties #(.NCH(NCH))
	edh_dma_handshake_properties_i (.core_clk(core_clk), .resetn(resetn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.ext_dma_grant_n(ext_dma_grant_n), .read_strobe_n(read_strobe_n),
	.write_strobe_n(write_strobe_n));

`default_nettype wire
